// [runaway_watchdog.sv]
// Runaway watchdog: 16-bit down counter, enable flag and two underflow flags
// Function
// - The 16-bit down counter counts instruction clocks and loads FFFF on reset release.
// - One count pulse arriving while the counter is 0000 sets the first underflow flag.
// - An underflow with the first flag already set sets the second flag and pulls reset low.
// - The watchdog is active whenever the enable flag is one after reset release.
// - A disable command followed directly by a service command clears the enable flag.
// - The enable flag is set on every system reset and on entry to back-up mode.
// - Service with the first flag set clears it and skips the next instruction, else no skip.
// - The service command's test-and-skip works even while the watchdog is disabled.
// - The disable command alone does not stop the watchdog.
// - Entry to back-up mode reinitialises the first flag and the counter.
// - After return from back-up the watchdog is active again.
`timescale 1ns/1ps
module runaway_watchdog
    import runaway_watchdog_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic instr_tick,
    input  wire logic service_and_skip_command,
    input  wire logic guard_disable_command,
    input  wire logic backup_entry,
    output logic      skip_next,
    output logic      chip_reset_n,
    output logic      guard_enable_flag,
    output logic      first_underflow_flag,
    output logic      second_underflow_flag
);
    import runaway_watchdog_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count_ff;
    logic             enable_ff;
    logic             first_underflow_flag_ff;
    logic             second_underflow_flag_ff;
    logic             disarm_ff;
    logic             skip_ff;
    logic             rst_n_ff;
    logic             backup_sync;

    // Back-up entry comes from the power controller, not this clock domain
    level_sync u_backup_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (backup_entry),
        .sync_out (backup_sync)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic             count_pulse;
    logic             underflow;
    logic             disable_now;
    logic             service_clear;
    logic [CNT_W-1:0] nxt_count;
    logic             nxt_enable;
    logic             nxt_first_underflow_flag;
    logic             nxt_disarm;

    // Counting stops while disabled; a tripped chip reset freezes it too
    assign count_pulse   = instr_tick && enable_ff && !second_underflow_flag_ff;
    assign underflow     = count_pulse && (count_ff == CNT_ZERO);
    // Only an immediately following service completes the disable
    assign disable_now   = disarm_ff && service_and_skip_command && instr_tick;
    assign service_clear = service_and_skip_command && instr_tick && first_underflow_flag_ff;
    assign nxt_count     = backup_sync ? CNT_RELOAD
                         : count_pulse ? count_ff - CNT_ONE : count_ff;
    // Underflow wins over a clear in the same cycle
    assign nxt_first_underflow_flag      = backup_sync ? 1'b0
                         : underflow ? 1'b1
                         : service_clear ? 1'b0 : first_underflow_flag_ff;
    assign nxt_enable    = backup_sync ? 1'b1
                         : disable_now ? 1'b0 : enable_ff;
    // Any other instruction boundary without a disable command drops a pending disable
    assign nxt_disarm    = instr_tick ? guard_disable_command : disarm_ff;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_ff  <= CNT_RELOAD;
            enable_ff <= 1'b1;
            first_underflow_flag_ff   <= 1'b0;
            disarm_ff <= 1'b0;
        end else begin
            count_ff  <= nxt_count;
            enable_ff <= nxt_enable;
            first_underflow_flag_ff   <= nxt_first_underflow_flag;
            disarm_ff <= nxt_disarm;
        end
    end

    // Second underflow latches until system reset; the reset pin follows it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            second_underflow_flag_ff  <= 1'b0;
            rst_n_ff <= 1'b1;
            skip_ff  <= 1'b0;
        end else begin
            second_underflow_flag_ff  <= second_underflow_flag_ff || (underflow && first_underflow_flag_ff && !backup_sync);
            rst_n_ff <= !(second_underflow_flag_ff || (underflow && first_underflow_flag_ff && !backup_sync));
            skip_ff  <= service_clear;
        end
    end

    assign skip_next             = skip_ff;
    assign chip_reset_n          = rst_n_ff;
    assign guard_enable_flag     = enable_ff;
    assign first_underflow_flag  = first_underflow_flag_ff;
    assign second_underflow_flag = second_underflow_flag_ff;

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // Service taken while the first flag is up and nothing overrides it
    sequence svc_with_flag;
        service_and_skip_command && instr_tick && first_underflow_flag_ff && !underflow && !backup_sync;
    endsequence

    // Disable armed by the previous instruction and completed by this service;
    // idle cycles in between are allowed, another instruction is not
    sequence disable_pair;
        disarm_ff && instr_tick && service_and_skip_command && !backup_sync;
    endsequence

    // Any instruction boundary that carries no disable command
    sequence other_instr;
        instr_tick && !guard_disable_command;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    reload_after_reset_a: assert property (@(posedge clk)
        $fell(sys_rst) |-> count_ff == CNT_RELOAD)
        else $error("counter not reloaded after reset");
    count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
        count_pulse && !backup_sync && count_ff != CNT_ZERO |=> count_ff == $past(count_ff) - 16'h0001)
        else $error("counter did not step down");
    underflow_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
        underflow && !backup_sync |=> first_underflow_flag_ff && count_ff == CNT_RELOAD)
        else $error("underflow not recorded");
    second_trip_a: assert property (@(posedge clk) disable iff (sys_rst)
        underflow && first_underflow_flag_ff && !backup_sync |=> second_underflow_flag_ff && !chip_reset_n)
        else $error("second underflow did not reset chip");
    service_skip_a: assert property (@(posedge clk) disable iff (sys_rst)
        svc_with_flag |=> skip_next && !first_underflow_flag_ff)
        else $error("service with flag did not skip");
    no_skip_a: assert property (@(posedge clk) disable iff (sys_rst)
        !first_underflow_flag_ff |=> !skip_next)
        else $error("skip without flag");
    disable_seq_a: assert property (@(posedge clk) disable iff (sys_rst)
        disable_pair |=> !guard_enable_flag)
        else $error("disable sequence ignored");
    lone_disable_a: assert property (@(posedge clk) disable iff (sys_rst)
        guard_enable_flag && !(disarm_ff && service_and_skip_command && instr_tick)
            |=> guard_enable_flag)
        else $error("watchdog stopped without full sequence");
    backup_init_a: assert property (@(posedge clk) disable iff (sys_rst)
        backup_sync |=> guard_enable_flag && !first_underflow_flag_ff && count_ff == CNT_RELOAD)
        else $error("back-up entry did not reinitialise");
    frozen_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !enable_ff && !backup_sync |=> $stable(count_ff))
        else $error("counter moved while disabled");

    reset_values_a: assert property (@(posedge clk)
        $fell(sys_rst) |-> guard_enable_flag && !first_underflow_flag
            && !second_underflow_flag && chip_reset_n)
        else $error("flags wrong after reset");

    reset_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
        second_underflow_flag |-> !chip_reset_n)
        else $error("reset pin released while second flag set");

    second_underflow_flag_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
        second_underflow_flag |=> second_underflow_flag)
        else $error("second flag cleared without reset");

    no_early_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        !first_underflow_flag_ff && !second_underflow_flag |=> chip_reset_n)
        else $error("chip reset without prior underflow");

    arm_on_cmd_a: assert property (@(posedge clk) disable iff (sys_rst)
        instr_tick && guard_disable_command |=> disarm_ff)
        else $error("disable command not armed");

    disarm_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        other_instr |=> !disarm_ff)
        else $error("pending disable survived another instruction");

    skip_disabled_a: assert property (@(posedge clk) disable iff (sys_rst)
        svc_with_flag and !enable_ff |=> skip_next)
        else $error("no skip while watchdog disabled");

    count_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !instr_tick && !backup_sync |=> $stable(count_ff))
        else $error("counter moved without instruction clock");

    flag_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !instr_tick && !backup_sync |=> $stable(first_underflow_flag_ff))
        else $error("first flag moved without instruction clock");

    stay_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !enable_ff && !backup_sync |=> !enable_ff)
        else $error("watchdog re-enabled without back-up entry");
endmodule

// [runaway_watchdog_pkg.sv]
// Package of constants for the runaway watchdog
package runaway_watchdog_pkg;
    localparam int          CNT_W          = 16;
    localparam logic [15:0] CNT_RELOAD     = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO       = 16'h0000;
    localparam logic [15:0] CNT_ONE        = 16'h0001;
    localparam int          SYNC_STAGES    = 2;
    localparam logic        SYNC_RESET_VAL = 1'b0;
endpackage

// [level_sync.sv]
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module level_sync
    import runaway_watchdog_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= SYNC_RESET_VAL;
            sync_ff <= SYNC_RESET_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// [test_runaway_watchdog.sv]
// Self-checking testbench for the runaway watchdog
`timescale 1ns/1ps
module test_runaway_watchdog;
    import runaway_watchdog_pkg::*;
    logic clk          = 1'b0;
    logic sys_rst      = 1'b1;
    logic instr_tick   = 1'b0;
    logic svc          = 1'b0;
    logic dis          = 1'b0;
    logic backup_entry = 1'b0;
    logic skip_next;
    logic chip_reset_n;
    logic guard_enable_flag;
    logic first_underflow_flag;
    logic second_underflow_flag;
    logic last_skip;
    int   err_count    = 0;
    int   n_compared   = 0;

    runaway_watchdog DUT (
        .clk                      (clk),
        .sys_rst                  (sys_rst),
        .instr_tick               (instr_tick),
        .service_and_skip_command (svc),
        .guard_disable_command    (dis),
        .backup_entry             (backup_entry),
        .skip_next                (skip_next),
        .chip_reset_n             (chip_reset_n),
        .guard_enable_flag        (guard_enable_flag),
        .first_underflow_flag     (first_underflow_flag),
        .second_underflow_flag    (second_underflow_flag)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One instruction; skip_next is caught in the cycle after it is taken
    task automatic tick(input logic s, input logic d);
        @(negedge clk);
        instr_tick = 1'b1;
        svc = s;
        dis = d;
        @(negedge clk);
        last_skip = skip_next;
        instr_tick = 1'b0;
        svc = 1'b0;
        dis = 1'b0;
    endtask

    // Back-to-back instruction clocks, no commands
    task automatic run(input int n);
        @(negedge clk);
        instr_tick = 1'b1;
        repeat (n) @(negedge clk);
        instr_tick = 1'b0;
    endtask

    task automatic give_verdict();
        $display("compared=%0d mismatches=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(guard_enable_flag, 1'b1);
        check(first_underflow_flag, 1'b0);
        check(second_underflow_flag, 1'b0);
        check(chip_reset_n, 1'b1);
        check(skip_next, 1'b0);
        $display("reset values done");
    endtask

    // An instruction between the two commands must cancel the disable
    task automatic t_disable();
        tick(1'b0, 1'b1);
        check(guard_enable_flag, 1'b1);
        tick(1'b0, 1'b0);
        tick(1'b1, 1'b0);
        check(guard_enable_flag, 1'b1);
        tick(1'b0, 1'b1);
        tick(1'b1, 1'b0);
        check(guard_enable_flag, 1'b0);
        check(last_skip, 1'b0);
        $display("disable sequence done");
    endtask

    task automatic t_backup();
        tick(1'b1, 1'b0);
        check(last_skip, 1'b0);
        @(negedge clk);
        backup_entry = 1'b1;
        repeat (5) @(negedge clk);
        backup_entry = 1'b0;
        repeat (5) @(negedge clk);
        check(guard_enable_flag, 1'b1);
        $display("back-up entry done");
    endtask

    // Counter restarts from full scale at back-up, so 65536 ticks underflow
    task automatic t_underflow();
        run(65535);
        check(first_underflow_flag, 1'b0);
        run(1);
        check(first_underflow_flag, 1'b1);
        check(chip_reset_n, 1'b1);
        check(second_underflow_flag, 1'b0);
        tick(1'b0, 1'b1);
        tick(1'b1, 1'b0);
        check(last_skip, 1'b1);
        check(first_underflow_flag, 1'b0);
        check(guard_enable_flag, 1'b0);
        tick(1'b1, 1'b0);
        check(last_skip, 1'b0);
        $display("underflow and service done");
    endtask

    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_disable();
        t_backup();
        t_underflow();
        give_verdict();
    end

    // Whole run is about 66k cycles; cut off at 80k
    initial begin
        #8_000_000;
        err_count++;
        give_verdict();
    end
endmodule
